// ### rxcfg_regs.v
// receive path configuration registers with subcarrier, squelch and gain control logic
//
// Contract
// [R1] five-bit start time in quarter etu, 0 to 7.75, type-B 106k only
// [R2] subcarrier earlier than start time after timer expiry raises soft error
// [R3] with suppression on, early frame is discarded and restart raised instead
// [R4] channel bit picks AM or PM, single channel or manual framing channel
// [R5] lowpass field and four zero bits forwarded unchanged to the filter
// [R6] demodulator bit picks AM/PM or I/Q; I/Q needs mixer selected
// [R7] AM demodulator bit: peak detector at 0, mixer at 1, reset 0
// [R8] dynamic squelch on 18.88 us after transmit, off at squelch time
// [R9] squelch ratio bit: trigger at 1 or 6/3 of digitizing threshold
// [R10] host should pick ratio 6/3 for fast correlator, 1 elsewhere
// [R11] gain control enable and mode: first eight pulses or whole reception
// [R12] gain algorithm bit: preset at 0, reset at 1
// [R13] host should pick preset algorithm for short start-of-frame protocols
// [R14] gain ratio bit: trigger at 3 or 6 times minimum level
// [R15] suppression enable input: off at 0, on at 1
// [R16] start register bits 7 to 5 read zero, ignore writes
// [R17] reset values 0x00, 0x00 and 0x2C
`timescale 1ns/1ps
`default_nettype none
`include "rxcfg_defines.vh"
module rxcfg_regs #(
  parameter SQ_DELAY_CYC = `RXCFG_SQ_DELAY_CYC,
  parameter AGC_PULSES = `RXCFG_AGC_PULSES
) (
  // clock, reset, enable
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  // host register port
  input wire host_space,
  input wire [5:0] host_addr,
  input wire host_wr,
  input wire [7:0] host_wdata,
  input wire host_rd,
  output reg [7:0] host_rdata_q,
  // receive events and status
  input wire emd_en,
  input wire proto_b106,
  input wire mrt_expired,
  input wire qetu_tick,
  input wire sc_detect,
  input wire tx_end,
  input wire mask_receive_timer_at_sqt,
  input wire rx_start,
  input wire rx_end,
  input wire sc_pulse,
  input wire am_chan_en,
  input wire pm_chan_en,
  input wire manual_sel,
  input wire auto_pick_pm,
  // subcarrier check results
  output wire soft_err_irq_q,
  output wire restart_irq_q,
  output wire frame_discard_q,
  // channel and filter settings
  output reg am_path_on_q,
  output reg pm_path_on_q,
  output reg framing_pm_q,
  output reg [2:0] lowpass_q,
  output reg [3:0] zero_setting_q,
  // demodulator
  output reg iq_mode_q,
  output reg amd_mixer_q,
  output reg demod_cfg_err_q,
  // squelch
  output wire squelch_on_q,
  output reg squelch_ratio63_q,
  // gain control
  output reg agc_active_q,
  output reg agc_reset_alg_q,
  output reg gain_control_ratio_q
);
  localparam PW = 4;
  localparam [PW-1:0] PULSE_LAST = AGC_PULSES - 1;

  reg [7:0] sst_q;
  reg [7:0] rcf_q;
  reg [7:0] dsg_q;
  reg [PW-1:0] pcnt_q;
  reg [7:0] rdata_d;
  wire hit_sst;
  wire hit_rcf;
  wire hit_dsg;
  wire both_en;
  wire one_en;
  wire choice;

  // ====================================================
  // address decode
  assign hit_sst = (host_space == `RXCFG_SPACE_B) && (host_addr == `RXCFG_OFS_SST);
  assign hit_rcf = (host_space == `RXCFG_SPACE_A) && (host_addr == `RXCFG_OFS_RCF);
  assign hit_dsg = (host_space == `RXCFG_SPACE_A) && (host_addr == `RXCFG_OFS_DSG);

  // ====================================================
  // register writes
  always @(posedge clk_sys) begin
    if (!nrst) begin
      sst_q <= `RXCFG_RST_SST; // [R17]
      rcf_q <= `RXCFG_RST_RCF; // [R17]
      dsg_q <= `RXCFG_RST_DSG; // [R17]
    end else if (ce && host_wr) begin
      if (hit_sst) begin
        sst_q <= host_wdata & `RXCFG_SST_MASK; // [R16]
      end
      if (hit_rcf) begin
        rcf_q <= host_wdata;
      end
      if (hit_dsg) begin
        dsg_q <= host_wdata;
      end
    end
  end

  // ====================================================
  // register reads, unmapped addresses return zero
  always @* begin
    rdata_d = 8'h00;
    if (hit_sst) begin
      rdata_d = sst_q & `RXCFG_SST_MASK; // [R16]
    end else if (hit_rcf) begin
      rdata_d = rcf_q;
    end else if (hit_dsg) begin
      rdata_d = dsg_q;
    end
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      host_rdata_q <= 8'h00;
    end else if (ce && host_rd) begin
      host_rdata_q <= rdata_d;
    end
  end

  // ====================================================
  // subcarrier start time check
  rxcfg_sst_chk #(
    .CW(5)
  ) u_sst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .sst_val(sst_q[4:0]),
    .proto_b106(proto_b106),
    .emd_en(emd_en),
    .mrt_expired(mrt_expired),
    .qetu_tick(qetu_tick),
    .sc_detect(sc_detect),
    .soft_err_q(soft_err_irq_q),
    .restart_q(restart_irq_q),
    .discard_q(frame_discard_q)
  );

  // ====================================================
  // dynamic squelch
  rxcfg_squelch #(
    .DELAY_CYC(SQ_DELAY_CYC),
    .CW(12)
  ) u_sq (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .dyn_en(dsg_q[`RXCFG_DSG_SQ_DYN]),
    .tx_end(tx_end),
    .mrt_at_sqt(mask_receive_timer_at_sqt),
    .squelch_q(squelch_on_q)
  );

  // ====================================================
  // channel selection
  assign both_en = am_chan_en && pm_chan_en;
  assign one_en = am_chan_en ^ pm_chan_en;
  assign choice = rcf_q[`RXCFG_RCF_CHOICE];

  always @(posedge clk_sys) begin
    if (!nrst) begin
      am_path_on_q <= 1'b0;
      pm_path_on_q <= 1'b0;
      framing_pm_q <= 1'b0;
    end else if (ce) begin
      if (both_en) begin
        am_path_on_q <= 1'b1;
        pm_path_on_q <= 1'b1;
        // automatic mode leaves the pick to the decoder
        framing_pm_q <= manual_sel ? choice : auto_pick_pm; // [R4]
      end else if (one_en) begin
        am_path_on_q <= ~choice; // [R4]
        pm_path_on_q <= choice; // [R4]
        framing_pm_q <= choice;
      end else begin
        am_path_on_q <= 1'b0;
        pm_path_on_q <= 1'b0;
        framing_pm_q <= 1'b0;
      end
    end
  end

  // ====================================================
  // filter, demodulator and trigger settings
  always @(posedge clk_sys) begin
    if (!nrst) begin
      lowpass_q <= 3'h0;
      zero_setting_q <= 4'h0;
      iq_mode_q <= 1'b0;
      amd_mixer_q <= 1'b0;
      demod_cfg_err_q <= 1'b0;
      squelch_ratio63_q <= 1'b0;
      agc_reset_alg_q <= 1'b0;
      gain_control_ratio_q <= 1'b0;
    end else if (ce) begin
      lowpass_q <= rcf_q[`RXCFG_RCF_LP_HI:`RXCFG_RCF_LP_LO]; // [R5]
      zero_setting_q <= rcf_q[`RXCFG_RCF_ZERO_HI:0]; // [R5]
      amd_mixer_q <= dsg_q[`RXCFG_DSG_AMD_SEL]; // [R7]
      // I/Q without the mixer is refused and flagged
      iq_mode_q <= dsg_q[`RXCFG_DSG_DEMOD_MODE] & dsg_q[`RXCFG_DSG_AMD_SEL]; // [R6]
      demod_cfg_err_q <= dsg_q[`RXCFG_DSG_DEMOD_MODE] & ~dsg_q[`RXCFG_DSG_AMD_SEL]; // [R6]
      squelch_ratio63_q <= dsg_q[`RXCFG_DSG_SQ_RATIO]; // [R9]
      agc_reset_alg_q <= dsg_q[`RXCFG_DSG_AGC_ALG]; // [R12]
      gain_control_ratio_q <= dsg_q[`RXCFG_DSG_AGC_RATIO]; // [R14]
    end
  end

  // ====================================================
  // gain control window
  always @(posedge clk_sys) begin
    if (!nrst) begin
      agc_active_q <= 1'b0;
      pcnt_q <= {PW{1'b0}};
    end else if (ce) begin
      if (!dsg_q[`RXCFG_DSG_AGC_EN]) begin
        agc_active_q <= 1'b0; // [R11]
      end else if (rx_start) begin
        agc_active_q <= 1'b1; // [R11]
        pcnt_q <= {PW{1'b0}};
      end else if (rx_end) begin
        agc_active_q <= 1'b0;
      end else if (agc_active_q && sc_pulse && !dsg_q[`RXCFG_DSG_AGC_MODE]) begin
        if (pcnt_q == PULSE_LAST) begin
          agc_active_q <= 1'b0; // [R11]
        end
        pcnt_q <= pcnt_q + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // rxcfg_regs
`default_nettype wire

// ### rxcfg_defines.vh
// register offsets, field positions, reset values and timing for the receive config bank
`ifndef RXCFG_DEFINES_VH
`define RXCFG_DEFINES_VH
// ====================================================
// register spaces and offsets
`define RXCFG_SPACE_A 1'h0
`define RXCFG_SPACE_B 1'h1
`define RXCFG_OFS_SST 6'h06
`define RXCFG_OFS_RCF 6'h0B
`define RXCFG_OFS_DSG 6'h0C
// ====================================================
// reset values
`define RXCFG_RST_SST 8'h00
`define RXCFG_RST_RCF 8'h00
`define RXCFG_RST_DSG 8'h2C
`define RXCFG_SST_MASK 8'h1F
// ====================================================
// receive_channel_filter_cfg fields
`define RXCFG_RCF_CHOICE 7
`define RXCFG_RCF_LP_HI 6
`define RXCFG_RCF_LP_LO 4
`define RXCFG_RCF_ZERO_HI 3
// ====================================================
// demod_squelch_gain_cfg fields
`define RXCFG_DSG_DEMOD_MODE 7
`define RXCFG_DSG_AMD_SEL 6
`define RXCFG_DSG_SQ_DYN 5
`define RXCFG_DSG_SQ_RATIO 4
`define RXCFG_DSG_AGC_EN 3
`define RXCFG_DSG_AGC_MODE 2
`define RXCFG_DSG_AGC_ALG 1
`define RXCFG_DSG_AGC_RATIO 0
// ====================================================
// timing
`define RXCFG_CLK_PERIOD_PS 10000
`define RXCFG_SQ_DELAY_PS 18880000
`define RXCFG_SQ_DELAY_CYC ((`RXCFG_SQ_DELAY_PS + `RXCFG_CLK_PERIOD_PS - 1) / `RXCFG_CLK_PERIOD_PS)
`define RXCFG_AGC_PULSES 8
`endif

// ### rxcfg_sst_chk.v
// subcarrier start time check after mask receive timer expiry
`timescale 1ns/1ps
`default_nettype none
module rxcfg_sst_chk #(
  parameter CW = 5
) (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  // settings
  input wire [CW-1:0] sst_val,
  input wire proto_b106,
  input wire emd_en,
  // receive events
  input wire mrt_expired,
  input wire qetu_tick,
  input wire sc_detect,
  // results
  output reg soft_err_q,
  output reg restart_q,
  output reg discard_q
);
  reg armed_q;
  reg [CW-1:0] cnt_q;
  wire early;
  // ====================================================
  // quarter etu counter, saturating so a late subcarrier never wraps to early
  assign early = cnt_q < sst_val;
  always @(posedge clk_sys) begin
    if (!nrst) begin
      armed_q <= 1'b0;
      cnt_q <= {CW{1'b0}};
      soft_err_q <= 1'b0;
      restart_q <= 1'b0;
      discard_q <= 1'b0;
    end else if (ce) begin
      soft_err_q <= 1'b0;
      restart_q <= 1'b0;
      discard_q <= 1'b0;
      if (mrt_expired) begin
        armed_q <= proto_b106; // [R1]
        cnt_q <= {CW{1'b0}};
      end else if (armed_q && sc_detect) begin
        armed_q <= 1'b0;
        if (early && emd_en) begin
          restart_q <= 1'b1; // [R3]
          discard_q <= 1'b1; // [R15]
        end else if (early) begin
          soft_err_q <= 1'b1; // [R2]
        end
      end else if (armed_q && qetu_tick && cnt_q != {CW{1'b1}}) begin
        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1}; // [R1]
      end
    end
  end
endmodule // rxcfg_sst_chk
`default_nettype wire

// ### rxcfg_squelch.v
// dynamic squelch window after end of transmission
`timescale 1ns/1ps
`default_nettype none
module rxcfg_squelch #(
  parameter DELAY_CYC = 1888,
  parameter CW = 12
) (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  input wire ce,
  // control and events
  input wire dyn_en,
  input wire tx_end,
  input wire mrt_at_sqt,
  // result
  output reg squelch_q
);
  localparam ST_IDLE = 2'b00;
  localparam ST_WAIT = 2'b01;
  localparam ST_ON = 2'b10;
  localparam [CW-1:0] LAST = DELAY_CYC - 1;
  reg [1:0] st_q;
  reg [CW-1:0] cnt_q;
  // ====================================================
  // state machine
  always @(posedge clk_sys) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      cnt_q <= {CW{1'b0}};
      squelch_q <= 1'b0;
    end else if (ce) begin
      if (!dyn_en) begin
        st_q <= ST_IDLE; // [R8]
        squelch_q <= 1'b0;
      end else if (tx_end) begin
        st_q <= ST_WAIT;
        cnt_q <= {CW{1'b0}};
        squelch_q <= 1'b0;
      end else begin
        case (st_q)
          ST_WAIT: begin
            if (mrt_at_sqt) begin
              st_q <= ST_IDLE;
            end else if (cnt_q == LAST) begin
              st_q <= ST_ON; // [R8]
              squelch_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
            end
          end
          ST_ON: begin
            if (mrt_at_sqt) begin
              st_q <= ST_IDLE; // [R8]
              squelch_q <= 1'b0;
            end
          end
          default: begin
            st_q <= ST_IDLE;
            squelch_q <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // rxcfg_squelch
`default_nettype wire

// ### rxcfg_host_bfm.sv
// host model driving the register port of the receive config bank
`timescale 1ns/1ps
`default_nettype none
module rxcfg_host_bfm (
  // clock
  input wire logic clk_sys,
  // register port
  output logic host_space,
  output logic [5:0] host_addr,
  output logic host_wr,
  output logic [7:0] host_wdata,
  output logic host_rd,
  input wire logic [7:0] host_rdata_q
);
  initial begin
    {host_space, host_addr, host_wr, host_wdata, host_rd} = '0;
  end
  // ====================================================
  // access tasks, entered at a falling edge
  task automatic wr(input logic sp, input logic [5:0] a, input logic [7:0] d);
    host_space = sp;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(negedge clk_sys);
    host_wr = 1'b0;
  endtask
  // data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic sp, input logic [5:0] a, output logic [7:0] d);
    host_space = sp;
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clk_sys);
    host_rd = 1'b0;
    d = host_rdata_q;
  endtask
endmodule // rxcfg_host_bfm
`default_nettype wire

// ### rxcfg_regs_checker.sv
// concurrent checks on the receive config bank ports
`timescale 1ns/1ps
`default_nettype none
`include "rxcfg_defines.vh"
module rxcfg_regs_checker (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // host port
  input wire logic host_space,
  input wire logic [5:0] host_addr,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic host_rd,
  input wire logic [7:0] host_rdata_q,
  // events
  input wire logic sc_detect,
  input wire logic mask_receive_timer_at_sqt,
  input wire logic rx_end,
  // results
  input wire logic soft_err_irq_q,
  input wire logic restart_irq_q,
  input wire logic frame_discard_q,
  input wire logic iq_mode_q,
  input wire logic amd_mixer_q,
  input wire logic demod_cfg_err_q,
  input wire logic squelch_on_q,
  input wire logic agc_active_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire logic is_sst = host_space == `RXCFG_SPACE_B && host_addr == `RXCFG_OFS_SST;
  wire logic is_dsg = host_space == `RXCFG_SPACE_A && host_addr == `RXCFG_OFS_DSG;
  // ====================================================
  // register port
  sequence s_wr_dsg; ce && host_wr && is_dsg; endsequence
  sequence s_rd_dsg; ce && host_rd && is_dsg; endsequence
  property p_wr_rd; s_wr_dsg ##1 s_rd_dsg |=> host_rdata_q == $past(host_wdata, 2); endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("readback differs from write");
  property p_rsv; ce && host_rd && is_sst |=> host_rdata_q[7:5] == 3'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  // reset must hold regardless of the default disable
  property p_rst;
    disable iff (1'b0) ce && !nrst |=> host_rdata_q == 8'h00 && !soft_err_irq_q
      && !squelch_on_q && !agc_active_q;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  // ====================================================
  // subcarrier check, demodulator, squelch, gain control
  property p_soft_cause; $rose(soft_err_irq_q) |-> $past(sc_detect) && !restart_irq_q; endproperty
  a_soft_cause: assert property (p_soft_cause) else $error("soft error without detect");
  property p_soft_one; ce && soft_err_irq_q |=> !soft_err_irq_q; endproperty
  a_soft_one: assert property (p_soft_one) else $error("soft error longer than a cycle");
  property p_discard; restart_irq_q == frame_discard_q; endproperty
  a_discard: assert property (p_discard) else $error("restart and discard differ");
  property p_rst_cause; $rose(restart_irq_q) |-> $past(sc_detect); endproperty
  a_rst_cause: assert property (p_rst_cause) else $error("restart without detect");
  property p_iq; iq_mode_q |-> amd_mixer_q && !demod_cfg_err_q; endproperty
  a_iq: assert property (p_iq) else $error("iq mode without mixer");
  property p_sq_off; ce && mask_receive_timer_at_sqt |-> ##2 !squelch_on_q; endproperty
  a_sq_off: assert property (p_sq_off) else $error("squelch held past timer");
  property p_agc_end; ce && rx_end |-> ##2 !agc_active_q; endproperty
  a_agc_end: assert property (p_agc_end) else $error("gain control past reception");
endmodule // rxcfg_regs_checker
bind rxcfg_regs rxcfg_regs_checker chk_u (.clk_sys, .nrst, .ce, .host_space, .host_addr,
  .host_wr, .host_wdata, .host_rd, .host_rdata_q, .sc_detect, .mask_receive_timer_at_sqt,
  .rx_end, .soft_err_irq_q, .restart_irq_q, .frame_discard_q, .iq_mode_q, .amd_mixer_q,
  .demod_cfg_err_q, .squelch_on_q, .agc_active_q);
`default_nettype wire

// ### tb.sv
// self-checking bench for the receive config bank
`timescale 1ns/1ps
`default_nettype none
`include "rxcfg_defines.vh"
module tb;
  logic clk_sys, nrst, ce, host_space, host_wr, host_rd;
  logic [5:0] host_addr;
  logic [7:0] host_wdata, host_rdata_q;
  logic emd_en, proto_b106, mrt_expired, qetu_tick, sc_detect, tx_end;
  logic mask_receive_timer_at_sqt, rx_start, rx_end, sc_pulse;
  logic am_chan_en, pm_chan_en, manual_sel, auto_pick_pm;
  logic soft_err_irq_q, restart_irq_q, frame_discard_q, am_path_on_q, pm_path_on_q;
  logic framing_pm_q, iq_mode_q, amd_mixer_q, demod_cfg_err_q, squelch_on_q;
  logic squelch_ratio63_q, agc_active_q, agc_reset_alg_q, gain_control_ratio_q;
  logic [2:0] lowpass_q;
  logic [3:0] zero_setting_q;
  int n_fail = 0;
  int cmp_count = 0;
  logic [7:0] dv [4] = '{8'h80, 8'hC0, 8'h13, 8'h2C};
  // short squelch delay keeps the run brief
  rxcfg_regs #(.SQ_DELAY_CYC(8)) dut_u (.clk_sys, .nrst, .ce, .host_space, .host_addr,
    .host_wr, .host_wdata, .host_rd, .host_rdata_q, .emd_en, .proto_b106, .mrt_expired,
    .qetu_tick, .sc_detect, .tx_end, .mask_receive_timer_at_sqt, .rx_start, .rx_end,
    .sc_pulse, .am_chan_en, .pm_chan_en, .manual_sel, .auto_pick_pm, .soft_err_irq_q,
    .restart_irq_q, .frame_discard_q, .am_path_on_q, .pm_path_on_q, .framing_pm_q,
    .lowpass_q, .zero_setting_q, .iq_mode_q, .amd_mixer_q, .demod_cfg_err_q,
    .squelch_on_q, .squelch_ratio63_q, .agc_active_q, .agc_reset_alg_q,
    .gain_control_ratio_q);
  rxcfg_host_bfm host_u (.clk_sys, .host_space, .host_addr, .host_wr, .host_wdata,
    .host_rd, .host_rdata_q);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ====================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic sp, input logic [5:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    host_u.rd(sp, a, v);
    chk(nm, e, v);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      sc_pulse = 1'b1;
      step(1);
      sc_pulse = 1'b0;
      step(1);
    end
  endtask
  // tick count must be at least one
  task automatic sc(input logic pb, input logic emd, input int t, input logic [7:0] e);
    proto_b106 = pb;
    emd_en = emd;
    mrt_expired = 1'b1;
    step(1);
    mrt_expired = 1'b0;
    qetu_tick = 1'b1;
    step(t);
    qetu_tick = 1'b0;
    sc_detect = 1'b1;
    step(1);
    sc_detect = 1'b0;
    // result stands for one cycle only, so look right after the detect edge
    chk("subcarrier", e, {5'h00, soft_err_irq_q, restart_irq_q, frame_discard_q});
    step(3);
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    {emd_en, proto_b106, mrt_expired, qetu_tick, sc_detect, tx_end} = '0;
    {mask_receive_timer_at_sqt, rx_start, rx_end, sc_pulse} = '0;
    {am_chan_en, pm_chan_en, manual_sel, auto_pick_pm} = '0;
    step(8);
    nrst = 1'b1;
    rdchk(`RXCFG_SPACE_B, `RXCFG_OFS_SST, 8'h00, "sst reset");
    rdchk(`RXCFG_SPACE_A, `RXCFG_OFS_RCF, 8'h00, "rcf reset");
    rdchk(`RXCFG_SPACE_A, `RXCFG_OFS_DSG, 8'h2C, "dsg reset");
    rdchk(`RXCFG_SPACE_A, 6'h3F, 8'h00, "unmapped");
    rdchk(`RXCFG_SPACE_B, `RXCFG_OFS_RCF, 8'h00, "wrong space");
    host_u.wr(`RXCFG_SPACE_B, `RXCFG_OFS_SST, 8'hFF);
    rdchk(`RXCFG_SPACE_B, `RXCFG_OFS_SST, 8'h1F, "sst mask");
    host_u.wr(`RXCFG_SPACE_B, `RXCFG_OFS_SST, 8'h02);
    sc(1'b1, 1'b0, 1, 8'h04);
    sc(1'b1, 1'b0, 2, 8'h00);
    sc(1'b1, 1'b1, 1, 8'h03);
    sc(1'b0, 1'b0, 1, 8'h00);
    {am_chan_en, pm_chan_en, manual_sel} = 3'h7;
    host_u.wr(`RXCFG_SPACE_A, `RXCFG_OFS_RCF, 8'hD5);
    rdchk(`RXCFG_SPACE_A, `RXCFG_OFS_RCF, 8'hD5, "rcf");
    chk("filter", 8'h55, {1'b0, lowpass_q, zero_setting_q});
    chk("channel both", 8'h07, {5'h00, am_path_on_q, pm_path_on_q, framing_pm_q});
    {am_chan_en, pm_chan_en, manual_sel} = 3'h4;
    host_u.wr(`RXCFG_SPACE_A, `RXCFG_OFS_RCF, 8'h00);
    step(2);
    chk("channel one", 8'h04, {5'h00, am_path_on_q, pm_path_on_q, framing_pm_q});
    for (int i = 0; i < 4; i++) begin
      host_u.wr(`RXCFG_SPACE_A, `RXCFG_OFS_DSG, dv[i]);
      rdchk(`RXCFG_SPACE_A, `RXCFG_OFS_DSG, dv[i], "dsg");
      chk("demod", {2'b00, dv[i][7] & dv[i][6], dv[i][6], dv[i][7] & ~dv[i][6], dv[i][4],
        dv[i][1], dv[i][0]}, {2'b00, iq_mode_q, amd_mixer_q, demod_cfg_err_q,
        squelch_ratio63_q, agc_reset_alg_q, gain_control_ratio_q});
    end
    tx_end = 1'b1;
    step(1);
    tx_end = 1'b0;
    step(3);
    chk("squelch wait", 8'h00, {7'h00, squelch_on_q});
    step(8);
    chk("squelch on", 8'h01, {7'h00, squelch_on_q});
    mask_receive_timer_at_sqt = 1'b1;
    step(1);
    mask_receive_timer_at_sqt = 1'b0;
    step(1);
    chk("squelch off", 8'h00, {7'h00, squelch_on_q});
    host_u.wr(`RXCFG_SPACE_A, `RXCFG_OFS_DSG, 8'h08);
    tx_end = 1'b1;
    step(1);
    tx_end = 1'b0;
    step(12);
    chk("squelch static", 8'h00, {7'h00, squelch_on_q});
    rx_start = 1'b1;
    step(1);
    rx_start = 1'b0;
    step(1);
    pulses(7);
    chk("agc seven", 8'h01, {7'h00, agc_active_q});
    pulses(1);
    chk("agc eight", 8'h00, {7'h00, agc_active_q});
    host_u.wr(`RXCFG_SPACE_A, `RXCFG_OFS_DSG, 8'h0C);
    rx_start = 1'b1;
    step(1);
    rx_start = 1'b0;
    pulses(9);
    chk("agc whole", 8'h01, {7'h00, agc_active_q});
    rx_end = 1'b1;
    step(1);
    rx_end = 1'b0;
    step(1);
    chk("agc end", 8'h00, {7'h00, agc_active_q});
    // a write while the enable is low must be lost
    ce = 1'b0;
    host_u.wr(`RXCFG_SPACE_A, `RXCFG_OFS_DSG, 8'hFF);
    ce = 1'b1;
    rdchk(`RXCFG_SPACE_A, `RXCFG_OFS_DSG, 8'h0C, "frozen");
    conclude;
  end
endmodule // tb
`default_nettype wire
